// *** src/gpio_port_pkg.sv ***
// Package for the eight-pin general-purpose port: register offsets, field
// positions, reset values and pin function encodings.
// Assumes a 16-bit register port with byte offsets as printed.
package gpio_port_pkg;

	localparam int PIN_COUNT  = 8;
	localparam int ADDR_WIDTH = 8;
	localparam int DATA_WIDTH = 16;

	// Register byte offsets.
	localparam logic [7:0] OFS_PIN_CONFIG        = 8'h00;
	localparam logic [7:0] OFS_PIN_OUTPUT_ENABLE = 8'h04;
	localparam logic [7:0] OFS_PIN_PULL_ENABLE   = 8'h08;
	localparam logic [7:0] OFS_PIN_INPUT_ENABLE  = 8'h0c;
	localparam logic [7:0] OFS_PIN_INPUT_LEVEL   = 8'h10;
	localparam logic [7:0] OFS_PIN_OUTPUT_LEVEL  = 8'h14;
	localparam logic [7:0] OFS_PIN_OUTPUT_SET    = 8'h18;
	localparam logic [7:0] OFS_PIN_OUTPUT_CLEAR  = 8'h1c;
	localparam logic [7:0] OFS_PIN_OUTPUT_TOGGLE = 8'h20;

	// Field positions inside the pin configuration register.
	localparam int PIN0_SEL_LSB = 0;
	localparam int PIN1_SEL_LSB = 2;
	localparam int SEL_WIDTH    = 2;

	// Reset values.
	localparam logic [3:0] CONFIG_RESET = 4'h0;
	localparam logic [7:0] BITS_RESET   = 8'h00;

	// Pin function encodings.
	typedef enum logic [1:0]
	{
		FUNC_A       = 2'h0,
		FUNC_TRIGGER = 2'h1,
		FUNC_SYNC    = 2'h2,
		FUNC_B       = 2'h3
	} pin_func_t;

endpackage : gpio_port_pkg

// *** src/pin_sync.sv ***
// Two-flop synchroniser bank for the pin input levels.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module pin_sync
(
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	input  wire logic [gpio_port_pkg::PIN_COUNT-1:0] asyncIn,
	output logic      [gpio_port_pkg::PIN_COUNT-1:0] syncOut
);
	import gpio_port_pkg::*;

	logic [PIN_COUNT-1:0] stage1_reg;

	// First stage feeds only the second stage.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			stage1_reg <= BITS_RESET;
			syncOut    <= BITS_RESET;
		end
		else
		begin
			stage1_reg <= asyncIn;
			syncOut    <= stage1_reg;
		end
	end

endmodule : pin_sync

// *** src/gpio_port.sv ***
// Eight-pin general-purpose port with per-pin drive, pull and input enables,
// output data with set, clear and toggle strobes, and function selection
// for pins 1 and 0.
// Assumes a simple register port and one clock; interrupt, sequencer,
// sync and hibernate sources come from logic on the same clock.
`timescale 1ns/1ps
module gpio_port
(
	input  wire logic                                 clk,
	input  wire logic                                 rst_n,
	input  wire logic [gpio_port_pkg::ADDR_WIDTH-1:0] regAddr,
	input  wire logic [gpio_port_pkg::DATA_WIDTH-1:0] regWdata,
	input  wire logic                                 regWrite,
	input  wire logic                                 regRead,
	output logic      [gpio_port_pkg::DATA_WIDTH-1:0] regRdata,
	input  wire logic [gpio_port_pkg::PIN_COUNT-1:0]  pinIn,
	output logic      [gpio_port_pkg::PIN_COUNT-1:0]  pinOut,
	output logic      [gpio_port_pkg::PIN_COUNT-1:0]  pinOe,
	output logic      [gpio_port_pkg::PIN_COUNT-1:0]  pullEnable,
	input  wire logic                                 irq0,
	input  wire logic                                 syncOut0,
	input  wire logic                                 syncOut1,
	input  wire logic                                 hibernate,
	output logic                                      seqTrigger0,
	output logic                                      seqTrigger1
);
	import gpio_port_pkg::*;

	logic [3:0]           config_reg;
	logic [PIN_COUNT-1:0] driveEnable_reg;
	logic [PIN_COUNT-1:0] pullEnable_reg;
	logic [PIN_COUNT-1:0] inputPath_reg;
	logic [PIN_COUNT-1:0] outLevel_reg;
	logic [PIN_COUNT-1:0] outLevel_next;
	logic [PIN_COUNT-1:0] pinSynced;
	logic [PIN_COUNT-1:0] inputLevel;
	logic [PIN_COUNT-1:0] gpioOut;
	logic [PIN_COUNT-1:0] gpioOe;
	logic [PIN_COUNT-1:0] wBits;
	logic [DATA_WIDTH-1:0] readMux;
	pin_func_t            pin0Func;
	pin_func_t            pin1Func;
	logic                 hitConfig;
	logic                 hitOe;
	logic                 hitPe;
	logic                 hitIe;
	logic                 hitIn;
	logic                 hitOut;
	logic                 hitSet;
	logic                 hitClr;
	logic                 hitTgl;
	logic                 wrConfig;
	logic                 wrDrive;
	logic                 wrPull;
	logic                 wrInput;
	logic                 wrLevel;
	logic                 wrSet;
	logic                 wrClr;
	logic                 wrTgl;
	logic                 pin0Out;
	logic                 pin0Oe;
	logic                 pin1Out;
	logic                 pin1Oe;
	logic [PIN_COUNT-1:0] plainOut;
	genvar                pinIdx;

	// Pin levels cross into the clock domain through two flops.
	pin_sync u_pin_sync
	(
		.clk     (clk),
		.rst_n   (rst_n),
		.asyncIn (pinIn),
		.syncOut (pinSynced)
	);

	// True when the bus address selects the register at the given offset.
	function automatic logic offset_hit
	(
		input logic [ADDR_WIDTH-1:0] addr,
		input logic [7:0]            ofs
	);
		return (addr == ofs);
	endfunction : offset_hit

	// Address decode.
	assign hitConfig = offset_hit(regAddr, OFS_PIN_CONFIG);
	assign hitOe     = offset_hit(regAddr, OFS_PIN_OUTPUT_ENABLE);
	assign hitPe     = offset_hit(regAddr, OFS_PIN_PULL_ENABLE);
	assign hitIe     = offset_hit(regAddr, OFS_PIN_INPUT_ENABLE);
	assign hitIn     = offset_hit(regAddr, OFS_PIN_INPUT_LEVEL);
	assign hitOut    = offset_hit(regAddr, OFS_PIN_OUTPUT_LEVEL);
	assign hitSet    = offset_hit(regAddr, OFS_PIN_OUTPUT_SET);
	assign hitClr    = offset_hit(regAddr, OFS_PIN_OUTPUT_CLEAR);
	assign hitTgl    = offset_hit(regAddr, OFS_PIN_OUTPUT_TOGGLE);
	assign wBits     = regWdata[PIN_COUNT-1:0];

	// Write strobes per register; writes to the input level and to
	// unmapped offsets match none of them and are dropped.
	assign wrConfig = regWrite & hitConfig;
	assign wrDrive  = regWrite & hitOe;
	assign wrPull   = regWrite & hitPe;
	assign wrInput  = regWrite & hitIe;
	assign wrLevel  = regWrite & hitOut;
	assign wrSet    = regWrite & hitSet;
	assign wrClr    = regWrite & hitClr;
	assign wrTgl    = regWrite & hitTgl;

	// Function selects for the two special pins.
	assign pin0Func = pin_func_t'(config_reg[PIN0_SEL_LSB +: SEL_WIDTH]);
	assign pin1Func = pin_func_t'(config_reg[PIN1_SEL_LSB +: SEL_WIDTH]);

	// Next output data: direct write, then set, clear or toggle strobes.
	// Zero bits of a strobe word leave their pins untouched.
	always_comb
	begin
		outLevel_next = outLevel_reg;
		if (wrLevel)
			outLevel_next = wBits;
		else if (wrSet)
			outLevel_next = outLevel_reg | wBits;
		else if (wrClr)
			outLevel_next = outLevel_reg & ~wBits;
		else if (wrTgl)
			outLevel_next = outLevel_reg ^ wBits;
	end

	// Pin function selects; only the low four bits exist.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			config_reg <= CONFIG_RESET;
		else if (wrConfig)
			config_reg <= regWdata[3:0];
	end

	// Drive enables, one bit per pin.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			driveEnable_reg <= BITS_RESET;
		else if (wrDrive)
			driveEnable_reg <= wBits;
	end

	// Pull resistor enables, one bit per pin.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pullEnable_reg <= BITS_RESET;
		else if (wrPull)
			pullEnable_reg <= wBits;
	end

	// Input path enables, one bit per pin.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			inputPath_reg <= BITS_RESET;
		else if (wrInput)
			inputPath_reg <= wBits;
	end

	// Output data takes its next value on every clock.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			outLevel_reg <= BITS_RESET;
		else
			outLevel_reg <= outLevel_next;
	end

	// Input level masked by the input path enables; the level is already
	// two flops past the pin, so any logic may read it from here on.
	assign inputLevel = pinSynced & inputPath_reg;

	// Trigger inputs reach the sequencer only in trigger mode, and only
	// while the input path of the pin is on.
	assign seqTrigger0 = (pin0Func == FUNC_TRIGGER) & inputLevel[0];
	assign seqTrigger1 = (pin1Func == FUNC_TRIGGER) & inputLevel[1];

	// Plain GPIO drive for every pin.
	assign gpioOut    = outLevel_reg;
	assign gpioOe     = driveEnable_reg;
	assign pullEnable = pullEnable_reg;

	// A GPIO pin shows its data bit only while its drive is on, so a
	// released pin never carries a stale level.
	generate
		for (pinIdx = 0; pinIdx < PIN_COUNT; pinIdx = pinIdx + 1)
		begin : g_plain_pin
			assign plainOut[pinIdx] = gpioOut[pinIdx] & gpioOe[pinIdx];
		end
	endgenerate

	// Pin 0 multiplexer; fixed functions drive the pin whatever the drive
	// enable says, and trigger mode leaves the pin to the host.
	always_comb
	begin
		case (pin0Func)
			FUNC_A:
			begin
				pin0Out = irq0;
				pin0Oe  = 1'h1;
			end
			FUNC_TRIGGER:
			begin
				pin0Out = 1'h0;
				pin0Oe  = 1'h0;
			end
			FUNC_SYNC:
			begin
				pin0Out = syncOut0;
				pin0Oe  = 1'h1;
			end
			default:
			begin
				pin0Out = plainOut[0];
				pin0Oe  = gpioOe[0];
			end
		endcase
	end

	// Pin 1 multiplexer; select 00 is plain GPIO, and the sleep flag
	// follows the hibernate level with no register in between.
	always_comb
	begin
		case (pin1Func)
			FUNC_TRIGGER:
			begin
				pin1Out = 1'h0;
				pin1Oe  = 1'h0;
			end
			FUNC_SYNC:
			begin
				pin1Out = syncOut1;
				pin1Oe  = 1'h1;
			end
			FUNC_B:
			begin
				pin1Out = hibernate;
				pin1Oe  = 1'h1;
			end
			default:
			begin
				pin1Out = plainOut[1];
				pin1Oe  = gpioOe[1];
			end
		endcase
	end

	// Pins 7 to 2 are plain GPIO; the two special pins sit below them.
	assign pinOut = {plainOut[PIN_COUNT-1:2], pin1Out, pin0Out};
	assign pinOe  = {gpioOe[PIN_COUNT-1:2], pin1Oe, pin0Oe};

	// Read selection; write-only and unmapped offsets read zero, so the
	// strobe registers never echo what software wrote to them.
	always_comb
	begin
		readMux = '0;
		if (hitConfig)
			readMux[3:0] = config_reg;
		else if (hitOe)
			readMux[PIN_COUNT-1:0] = driveEnable_reg;
		else if (hitPe)
			readMux[PIN_COUNT-1:0] = pullEnable_reg;
		else if (hitIe)
			readMux[PIN_COUNT-1:0] = inputPath_reg;
		else if (hitIn)
			readMux[PIN_COUNT-1:0] = inputLevel;
		else if (hitOut)
			readMux[PIN_COUNT-1:0] = outLevel_reg;
	end

	// Read data stands one cycle after the read strobe only; it returns
	// to zero otherwise, so stale data cannot be mistaken for an answer.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			regRdata <= '0;
		else if (regRead)
			regRdata <= readMux;
		else
			regRdata <= '0;
	end

endmodule : gpio_port

// *** dv/gpio_port_sva.sv ***
// Checker for the pin port, watching only its ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module gpio_port_sva
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [7:0]  regAddr,
	input wire logic [15:0] regWdata,
	input wire logic        regWrite,
	input wire logic        regRead,
	input wire logic [15:0] regRdata,
	input wire logic [7:0]  pinOut,
	input wire logic [7:0]  pinOe,
	input wire logic [7:0]  pullEnable,
	input wire logic        seqTrigger1
);
	import gpio_port_pkg::*;
	// Register decodes; pins 7..2 are plain GPIO and follow the registers alone.
	wire       wOe  = regWrite && regAddr == OFS_PIN_OUTPUT_ENABLE;
	wire       wPe  = regWrite && regAddr == OFS_PIN_PULL_ENABLE;
	wire       wSet = regWrite && regAddr == OFS_PIN_OUTPUT_SET;
	wire       wClr = regWrite && regAddr == OFS_PIN_OUTPUT_CLEAR;
	wire       wTgl = regWrite && regAddr == OFS_PIN_OUTPUT_TOGGLE;
	wire       wOut = regWrite && regAddr == OFS_PIN_OUTPUT_LEVEL;
	wire       rOut = regRead && regAddr == OFS_PIN_OUTPUT_LEVEL;
	wire [5:0] hi   = pinOut[7:2];
	wire [5:0] en   = pinOe[7:2];
	wire [5:0] wd   = regWdata[7:2];
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_drive_enable: assert property (wOe |=> en == $past(wd))
		else $error("Drive enable not applied.");
	a_pull_enable: assert property (wPe |=> pullEnable == $past(regWdata[7:0]))
		else $error("Pull enable not applied.");
	a_set_high: assert property (wSet |=> hi == (($past(hi) | $past(wd)) & en))
		else $error("Set strobe wrong.");
	a_clear_low: assert property (wClr |=> hi == ($past(hi) & ~$past(wd)))
		else $error("Clear strobe wrong.");
	a_toggle_inv: assert property (wTgl |=> hi == (($past(hi) ^ $past(wd)) & en))
		else $error("Toggle strobe wrong.");
	a_gpio_hiz: assert property ((hi & ~en) == 6'h00)
		else $error("Undriven pin shows a level.");
	a_out_readback: assert property (wOut ##1 !regWrite ##1 rOut |->
		##1 regRdata == {8'h00, $past(regWdata[7:0], 3)})
		else $error("Output data readback wrong.");
	a_trigger_in: assert property (seqTrigger1 |-> !pinOe[1])
		else $error("Trigger pin is driven.");
	// Main scenarios reached.
	c_toggle: cover property (wTgl);
	c_readback: cover property (wOut ##2 rOut);
	c_trigger: cover property (seqTrigger1);
endmodule : gpio_port_sva

bind gpio_port gpio_port_sva chk (.clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
	.regRdata, .pinOut, .pinOe, .pullEnable, .seqTrigger1);

// *** dv/pin_partner.sv ***
// Model of the host and the wiring on the eight pins.
// Assumes one wire per pin, resolved from the port's enables.
`timescale 1ns/1ps
module pin_partner
(
	input  wire logic [7:0] pinOut,
	input  wire logic [7:0] pinOe,
	input  wire logic [7:0] pullEnable,
	input  wire logic [7:0] hostLevel,
	output logic      [7:0] pinIn
);
	// Port drive wins, a pulled pin rests high, else the host drives it.
	assign pinIn = (pinOe & pinOut) | (~pinOe & (pullEnable | hostLevel));
endmodule : pin_partner

// *** dv/test_gpio_port0_pin_control.sv ***
// Bench for the pin port: registers, strobes, input path and pin modes.
// Assumes the bound checker and a pin model on the far side.
`timescale 1ns/1ps
module test_gpio_port0_pin_control;
	import gpio_port_pkg::*;
	logic        clk = 1'h0, rst_n = 1'h0, regWrite = 1'h0, regRead = 1'h0, irq0 = 1'h0;
	logic        syncOut0 = 1'h0, syncOut1 = 1'h0, hibernate = 1'h0, seqTrigger0, seqTrigger1;
	logic [7:0]  regAddr = 8'h00, hostLevel = 8'h00, pinIn, pinOut, pinOe, pullEnable;
	logic [15:0] regWdata = 16'h0000, regRdata;
	int          err_total = 0, num_checks = 0;
	// Free-running 200 MHz clock.
	always #2.5 clk = ~clk;
	gpio_port DUT (.clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
		.pinIn, .pinOut, .pinOe, .pullEnable, .irq0, .syncOut0, .syncOut1, .hibernate,
		.seqTrigger0, .seqTrigger1);
	pin_partner farSide (.pinOut, .pinOe, .pullEnable, .hostLevel, .pinIn);
	// Compares one value and counts the outcome.
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One write cycle, then an idle cycle so strobes never collide.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		regWrite <= 1'h1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'h0;
		@(posedge clk);
	endtask : wr
	// One read cycle; the data stand only in the following cycle.
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		regRead <= 1'h1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'h0;
		@(posedge clk);
		check(regRdata, exp);
	endtask : rd
	// Every place reads zero after reset, unmapped 0x24 too; pin 0 is the interrupt.
	task automatic t_reset();
		for (int a = 0; a <= 'h24; a += 4)
			rd(8'(a), 16'h0000);
		check({8'h00, pinOe}, 16'h0001);
	endtask : t_reset
	// Enables take the low byte only; the input level ignores writes.
	task automatic t_regs();
		wr(OFS_PIN_OUTPUT_ENABLE, 16'hfffc);
		wr(OFS_PIN_PULL_ENABLE, 16'h5aa5);
		wr(OFS_PIN_INPUT_LEVEL, 16'h00ff);
		rd(OFS_PIN_OUTPUT_ENABLE, 16'h00fc);
		check({8'h00, pinOe}, 16'h00fd);
		check({8'h00, pullEnable}, 16'h00a5);
		rd(OFS_PIN_INPUT_LEVEL, 16'h0000);
	endtask : t_regs
	// Set, clear and toggle touch only the ones they are given.
	task automatic t_strobe();
		wr(OFS_PIN_OUTPUT_LEVEL, 16'hff0f);
		rd(OFS_PIN_OUTPUT_LEVEL, 16'h000f);
		check({8'h00, pinOut & 8'hfc}, 16'h000c);
		wr(OFS_PIN_OUTPUT_SET, 16'h0030);
		check({8'h00, pinOut & 8'hfc}, 16'h003c);
		wr(OFS_PIN_OUTPUT_CLEAR, 16'h0024);
		check({8'h00, pinOut & 8'hfc}, 16'h0018);
		wr(OFS_PIN_OUTPUT_TOGGLE, 16'h00f0);
		rd(OFS_PIN_OUTPUT_LEVEL, 16'h00eb);
		rd(OFS_PIN_OUTPUT_SET, 16'h0000);
	endtask : t_strobe
	// Undriven pins read the host level only where the input path is on.
	task automatic t_input();
		wr(OFS_PIN_OUTPUT_ENABLE, 16'h0000);
		check({8'h00, pinOut & 8'hfc}, 16'h0000);
		wr(OFS_PIN_PULL_ENABLE, 16'h0000);
		wr(OFS_PIN_INPUT_ENABLE, 16'h000f);
		hostLevel <= 8'ha6;
		repeat (3) @(posedge clk);
		rd(OFS_PIN_INPUT_LEVEL, 16'h0006);
	endtask : t_input
	// Every function of pins 1 and 0; each entry is trig1,trig0,oe1,oe0,out1,out0.
	task automatic t_modes();
		logic [5:0] e [4] = '{6'h05, 6'h30, 6'h0f, 6'h08};
		irq0      <= 1'h1;
		syncOut0  <= 1'h1;
		syncOut1  <= 1'h1;
		hostLevel <= 8'h03;
		for (int m = 0; m < 4; m++)
		begin
			wr(OFS_PIN_CONFIG, 16'(m * 5));
			repeat (2) @(posedge clk);
			check({10'h000, seqTrigger1, seqTrigger0, pinOe[1:0], pinOut[1:0] & pinOe[1:0]},
				{10'h000, e[m]});
			rd(OFS_PIN_CONFIG, 16'(m * 5));
		end
		hibernate <= 1'h1;
		for (int n = 0; n < 8 && pinOut[1] !== 1'h1; n++)
			@(posedge clk);
		check({15'h0000, pinOut[1]}, 16'h0001);
	endtask : t_modes
	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	// Reset for six cycles, then the scenarios in turn.
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_reset();
		t_regs();
		t_strobe();
		t_input();
		t_modes();
		summarize();
	end
endmodule : test_gpio_port0_pin_control
